// *** dmsc_screen.sv ***
`timescale 1ns/10ps
`default_nettype none

module dmsc_screen #(
  parameter bit ZLR_SUPPORT = 1'b1
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_platform_rejects_cross,
  input  wire logic                         i_req_valid,
  output logic                              o_req_ready,
  input  wire logic [dmsc_pkg::RID_W-1:0]   i_req_rid,
  input  wire logic                         i_req_pasid_vld,
  input  wire logic [dmsc_pkg::PASID_W-1:0] i_req_pasid,
  input  wire dmsc_pkg::dmsc_kind_e         i_req_kind,
  input  wire logic [dmsc_pkg::ADDR_W-1:0]  i_req_addr,
  input  wire logic [dmsc_pkg::LEN_W-1:0]   i_req_len,
  input  wire logic [3:0]                   i_req_first_be,
  input  wire logic [3:0]                   i_req_last_be,
  output logic                              o_xl_valid,
  input  wire logic                         i_xl_ready,
  output logic [dmsc_pkg::RID_W-1:0]        o_xl_rid,
  output logic                              o_xl_pasid_vld,
  output logic [dmsc_pkg::PASID_W-1:0]      o_xl_pasid,
  output dmsc_pkg::dmsc_kind_e              o_xl_kind,
  output logic [dmsc_pkg::ADDR_W-1:0]       o_xl_addr,
  output logic [dmsc_pkg::CNT_W-1:0]        o_xl_len_dw,
  output logic                              o_xl_zero_len,
  input  wire logic                         i_xl_done,
  input  wire logic                         i_xl_fault,
  input  wire logic                         i_xl_rd_perm_only,
  output logic                              o_zero_len_read_support,
  output logic                              o_done,
  output logic                              o_cpl_ok,
  output logic                              o_cpl_be_off,
  output logic                              o_cpl_obfuscate,
  output logic                              o_cpl_bypass,
  output logic                              o_irq_msg,
  output logic                              o_irq_fault,
  output logic                              o_malformed,
  output logic                              o_xl_fault_rpt,
  output logic [dmsc_pkg::ADDR_W-1:0]       o_err_addr,
  output logic [dmsc_pkg::RID_W-1:0]        o_err_rid
);
  import dmsc_pkg::*;

  // ************************************************************
  // Request registers and classifier
  // ************************************************************
  dmsc_state_e       st_q;
  dmsc_state_e       st_d;
  logic [ADDR_W-1:0] cur_addr_q;
  logic [CNT_W-1:0]  rem_q;
  logic              first_q;
  logic              zl_q;
  logic              fault_q;
  logic              obf_q;
  logic [3:0]        fbe_q;
  logic [3:0]        lbe_q;

  dmsc_cls_if cif ();

  // The classifier always looks at the piece currently being worked on.
  assign cif.addr      = cur_addr_q;
  assign cif.len_dw    = rem_q;
  assign cif.kind      = o_xl_kind;
  assign cif.first_be  = fbe_q;
  assign cif.last_be   = lbe_q;
  assign cif.pasid_vld = o_xl_pasid_vld;

  dmsc_classify u_cls (
    .c (cif.cls)
  );

  // ************************************************************
  // Decisions
  // ************************************************************
  // A length field of zero means the largest request, 1024 doublewords.
  wire [CNT_W-1:0] req_len_dw  = {i_req_len == 10'h000, i_req_len};
  wire             accept      = (st_q == ST_IDLE) && i_req_valid;
  wire             go_malform  = first_q && cif.crosses && i_platform_rejects_cross;
  wire             go_irq      = first_q && cif.irq_win;
  wire             in_class    = st_q == ST_CLASS;
  wire             piece_done  = (st_q == ST_WAIT) && i_xl_done;
  // Only a pure read-permission failure on a flush may be forgiven.
  wire             forgiven    = ZLR_SUPPORT && zl_q && i_xl_rd_perm_only;
  wire             real_fault  = i_xl_fault && !forgiven;
  wire [CNT_W-1:0] rem_left    = rem_q - o_xl_len_dw;
  wire             more        = rem_left != RST_CNT;
  wire             finish_xl   = piece_done && !more;
  wire             direct      = in_class && (go_malform || go_irq);

  // ************************************************************
  // Controller state
  // ************************************************************
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (i_req_valid) begin
          st_d = ST_CLASS;
        end
      end
      ST_CLASS: begin
        st_d = direct ? ST_IDLE : ST_ISSUE;
      end
      ST_ISSUE: begin
        if (i_xl_ready) begin
          st_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (i_xl_done) begin
          st_d = more ? ST_CLASS : ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q        <= RST_STATE;
      o_req_ready <= 1'b1;
    end else begin
      st_q        <= st_d;
      o_req_ready <= st_d == ST_IDLE;
    end
  end

  // ************************************************************
  // Captured request and piece walk
  // ************************************************************
  // The requester-id is kept whole so phantom function numbers select their own context.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_xl_rid       <= '0;
      o_xl_pasid_vld <= 1'b0;
      o_xl_pasid     <= '0;
      o_xl_kind      <= DMSC_RD;
      fbe_q          <= 4'h0;
      lbe_q          <= 4'h0;
    end else if (accept) begin
      o_xl_rid       <= i_req_rid;
      o_xl_pasid_vld <= i_req_pasid_vld;
      o_xl_pasid     <= i_req_pasid;
      o_xl_kind      <= i_req_kind;
      fbe_q          <= i_req_first_be;
      lbe_q          <= i_req_last_be;
    end
  end

  // Each piece advances the address by the bytes it covered.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_addr_q <= RST_ADDR;
      rem_q      <= RST_CNT;
      first_q    <= 1'b0;
    end else if (accept) begin
      cur_addr_q <= i_req_addr;
      rem_q      <= req_len_dw;
      first_q    <= 1'b1;
    end else if (piece_done && more) begin
      cur_addr_q <= cur_addr_q + {51'h0, o_xl_len_dw, 2'b00};
      rem_q      <= rem_left;
      first_q    <= 1'b0;
    end
  end

  // ************************************************************
  // Translation request towards the table walker
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_xl_valid    <= 1'b0;
      o_xl_addr     <= RST_ADDR;
      o_xl_len_dw   <= RST_CNT;
      o_xl_zero_len <= 1'b0;
    end else if (in_class && !direct) begin
      o_xl_valid    <= 1'b1;
      o_xl_addr     <= cur_addr_q;
      o_xl_len_dw   <= cif.piece_dw;
      o_xl_zero_len <= cif.zero_len;
    end else if (i_xl_ready) begin
      o_xl_valid    <= 1'b0;
    end
  end

  // ************************************************************
  // Fault and obfuscation accumulation over all pieces
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      zl_q    <= 1'b0;
      fault_q <= 1'b0;
      obf_q   <= 1'b0;
    end else if (accept) begin
      zl_q    <= 1'b0;
      fault_q <= 1'b0;
      obf_q   <= 1'b0;
    end else begin
      if (in_class && first_q) begin
        zl_q <= cif.zero_len;
      end
      if (piece_done) begin
        fault_q <= fault_q || real_fault;
        obf_q   <= obf_q || (forgiven && i_xl_fault);
      end
    end
  end

  // ************************************************************
  // Outcome pulses, one cycle each, all on the final cycle of a request
  // ************************************************************
  wire end_fault = fault_q || real_fault;
  wire end_obf   = obf_q || (forgiven && i_xl_fault);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_done          <= 1'b0;
      o_cpl_ok        <= 1'b0;
      o_cpl_be_off    <= 1'b0;
      o_cpl_obfuscate <= 1'b0;
      o_cpl_bypass    <= 1'b0;
      o_irq_msg       <= 1'b0;
      o_irq_fault     <= 1'b0;
      o_malformed     <= 1'b0;
      o_xl_fault_rpt  <= 1'b0;
    end else begin
      o_done          <= direct || finish_xl;
      o_malformed     <= in_class && go_malform;
      o_irq_msg       <= in_class && !go_malform && go_irq && cif.irq_msg;
      o_irq_fault     <= in_class && !go_malform && go_irq
                         && !cif.irq_msg && !cif.zero_len;
      o_cpl_bypass    <= in_class && !go_malform && go_irq && cif.zero_len;
      o_cpl_ok        <= (in_class && !go_malform && go_irq && cif.zero_len)
                         || (finish_xl && !end_fault);
      o_cpl_be_off    <= (in_class && !go_malform && go_irq && cif.zero_len)
                         || (finish_xl && !end_fault && zl_q);
      o_cpl_obfuscate <= (in_class && !go_malform && go_irq && cif.zero_len)
                         || (finish_xl && !end_fault && end_obf);
      o_xl_fault_rpt  <= finish_xl && end_fault;
    end
  end

  // The error report names the original request, never a split piece.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_err_addr <= RST_ADDR;
      o_err_rid  <= '0;
    end else if (accept) begin
      o_err_addr <= i_req_addr;
      o_err_rid  <= i_req_rid;
    end
  end

  // The capability is a build choice; enabling it is the preferred build.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_zero_len_read_support <= 1'b0;
    end else begin
      o_zero_len_read_support <= ZLR_SUPPORT;
    end
  end

endmodule : dmsc_screen

`default_nettype wire

// *** dmsc_pkg.sv ***
package dmsc_pkg;

  // ************************************************************
  // Widths and page geometry
  // ************************************************************
  localparam int unsigned ADDR_W      = 64;
  localparam int unsigned RID_W       = 16;
  localparam int unsigned PASID_W     = 20;
  localparam int unsigned LEN_W       = 10;
  localparam int unsigned CNT_W       = 11;
  localparam int unsigned PAGE_OFS_W  = 12;
  localparam logic [12:0] PAGE_BYTES  = 13'h1000;
  localparam logic [CNT_W-1:0] ONE_DW = 11'h001;

  // ************************************************************
  // Interrupt address window: bits 31..20 equal FEE, upper half zero
  // ************************************************************
  localparam int unsigned IRQ_TAG_LSB = 20;
  localparam logic [11:0] IRQ_WIN_TAG = 12'hFEE;

  // ************************************************************
  // Request kinds and controller states
  // ************************************************************
  typedef enum logic [2:0] {
    DMSC_RD = 3'h1,
    DMSC_WR = 3'h2,
    DMSC_AT = 3'h4
  } dmsc_kind_e;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_CLASS = 4'h2,
    ST_ISSUE = 4'h4,
    ST_WAIT  = 4'h8
  } dmsc_state_e;

  // ************************************************************
  // Values after reset
  // ************************************************************
  localparam dmsc_state_e    RST_STATE = ST_IDLE;
  localparam logic [ADDR_W-1:0] RST_ADDR = 64'h0;
  localparam logic [CNT_W-1:0]  RST_CNT  = 11'h000;

endpackage : dmsc_pkg

// *** dmsc_cls_if.sv ***
`timescale 1ns/10ps
`default_nettype none

// Carries the current request fields to the classifier and its verdicts back.
interface dmsc_cls_if;
  import dmsc_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [CNT_W-1:0]  len_dw;
  dmsc_kind_e        kind;
  logic [3:0]        first_be;
  logic [3:0]        last_be;
  logic              pasid_vld;
  logic              crosses;
  logic              zero_len;
  logic              irq_win;
  logic              irq_msg;
  logic [CNT_W-1:0]  piece_dw;

  modport ctl (output addr, len_dw, kind, first_be, last_be, pasid_vld,
               input  crosses, zero_len, irq_win, irq_msg, piece_dw);
  modport cls (input  addr, len_dw, kind, first_be, last_be, pasid_vld,
               output crosses, zero_len, irq_win, irq_msg, piece_dw);
endinterface : dmsc_cls_if

`default_nettype wire

// *** dmsc_classify.sv ***
`timescale 1ns/10ps
`default_nettype none

module dmsc_classify (
  dmsc_cls_if.cls c
);
  import dmsc_pkg::*;

  // ************************************************************
  // Distance to the next page boundary, in doublewords
  // ************************************************************
  wire [12:0]      to_page_b = PAGE_BYTES - {1'b0, c.addr[PAGE_OFS_W-1:0]};
  wire [CNT_W-1:0] to_page_dw = to_page_b[12:2];

  // A request crosses when it needs more doublewords than remain in its page.
  assign c.crosses  = c.len_dw > to_page_dw;
  assign c.piece_dw = c.crosses ? to_page_dw : c.len_dw;

  // A one-doubleword read with no byte enabled is a flush, not a data read.
  assign c.zero_len = (c.kind == DMSC_RD) && (c.len_dw == ONE_DW)
                      && (c.first_be == 4'h0) && (c.last_be == 4'h0);

  // Only requests without a PASID are screened against the interrupt window.
  assign c.irq_win  = !c.pasid_vld && (c.addr[ADDR_W-1:32] == 32'h0)
                      && (c.addr[31:IRQ_TAG_LSB] == IRQ_WIN_TAG);
  assign c.irq_msg  = c.irq_win && (c.kind == DMSC_WR)
                      && (c.len_dw == ONE_DW);

endmodule : dmsc_classify

`default_nettype wire

// *** dmsc_screen_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// Port-level checks of the request screener
// ************************************************************
module dmsc_screen_assertions (
  input wire logic                  i_clk,
  input wire logic                  i_rst_n,
  input wire logic                  i_platform_rejects_cross,
  input wire logic                  i_req_valid,
  input wire logic                  o_req_ready,
  input wire logic                  i_req_pasid_vld,
  input wire dmsc_pkg::dmsc_kind_e  i_req_kind,
  input wire logic [63:0]           i_req_addr,
  input wire logic [9:0]            i_req_len,
  input wire logic [3:0]            i_req_first_be,
  input wire logic                  o_xl_valid,
  input wire logic                  i_xl_ready,
  input wire logic [63:0]           o_xl_addr,
  input wire logic [10:0]           o_xl_len_dw,
  input wire logic                  o_zero_len_read_support,
  input wire logic                  o_done,
  input wire logic                  o_cpl_ok,
  input wire logic                  o_cpl_be_off,
  input wire logic                  o_cpl_obfuscate,
  input wire logic                  o_cpl_bypass,
  input wire logic                  o_irq_msg,
  input wire logic                  o_irq_fault,
  input wire logic                  o_malformed
);
  import dmsc_pkg::*;
  logic acc, inw, win, zl, msg, crs;

  // Request decode; a length field of zero stands for 1024 doublewords.
  assign acc = i_req_valid && o_req_ready;
  assign inw = i_req_addr[63:32] == 32'h0 && i_req_addr[31:20] == IRQ_WIN_TAG;
  assign win = inw && !i_req_pasid_vld;
  assign zl  = i_req_kind == DMSC_RD && i_req_len == 10'h001 && i_req_first_be == 4'h0;
  assign msg = i_req_kind == DMSC_WR && i_req_len == 10'h001;
  assign crs = ({2'h0, i_req_addr[11:0]} + {1'b0, i_req_len == 10'h0, i_req_len, 2'h0}) > 14'h1000;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  chk_cap_set: assert property ($past(i_rst_n) |-> o_zero_len_read_support)
    else $error("zero length read capability not reported set");
  chk_piece_stable: assert property (o_xl_valid && !i_xl_ready |=> o_xl_valid && $stable(o_xl_addr))
    else $error("piece changed before it was taken");
  chk_piece_page: assert property (o_xl_valid |-> ({2'h0, o_xl_addr[11:0]} + {1'b0, o_xl_len_dw, 2'h0}) <= 14'h1000)
    else $error("piece crosses a page");
  chk_malformed_early: assert property (acc && crs && i_platform_rejects_cross |-> ##2 o_done && o_malformed)
    else $error("crossing request not reported malformed");
  chk_win_no_xl: assert property (acc && win |=> !o_xl_valid [*3])
    else $error("window request sent to translation");
  chk_win_bypass: assert property (acc && win && zl |-> ##2 o_done && o_cpl_bypass && o_cpl_obfuscate)
    else $error("window zero length read not bypassed");
  chk_win_irq_msg: assert property (acc && win && msg && !crs |-> ##2 o_done && o_irq_msg && !o_cpl_ok)
    else $error("window doubleword write not handed to interrupts");
  chk_win_irq_fault: assert property (acc && win && !zl && !msg && !(i_platform_rejects_cross && crs)
                                      |-> ##2 o_done && o_irq_fault)
    else $error("illegal window request not faulted");
  chk_pasid_xlate: assert property (acc && inw && i_req_pasid_vld && !(i_platform_rejects_cross && crs)
                                    |-> ##2 o_xl_valid)
    else $error("window request with pasid not translated");
  chk_be_off_ok: assert property (o_cpl_be_off |-> o_cpl_ok && o_done)
    else $error("byte enables off without a good completion");
  chk_obf_zero: assert property (o_cpl_obfuscate |-> o_cpl_be_off)
    else $error("obfuscated data on a non zero length read");

  cov_split: cover property (acc && crs && !i_platform_rejects_cross);
  cov_forgive: cover property (o_done && o_cpl_obfuscate && !o_cpl_bypass);
  cov_irq: cover property (o_done && o_irq_msg);
endmodule : dmsc_screen_assertions

bind dmsc_screen dmsc_screen_assertions u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_platform_rejects_cross(i_platform_rejects_cross),
  .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .i_req_pasid_vld(i_req_pasid_vld),
  .i_req_kind(i_req_kind), .i_req_addr(i_req_addr), .i_req_len(i_req_len), .i_req_first_be(i_req_first_be),
  .o_xl_valid(o_xl_valid), .i_xl_ready(i_xl_ready), .o_xl_addr(o_xl_addr), .o_xl_len_dw(o_xl_len_dw),
  .o_zero_len_read_support(o_zero_len_read_support), .o_done(o_done), .o_cpl_ok(o_cpl_ok),
  .o_cpl_be_off(o_cpl_be_off), .o_cpl_obfuscate(o_cpl_obfuscate), .o_cpl_bypass(o_cpl_bypass),
  .o_irq_msg(o_irq_msg), .o_irq_fault(o_irq_fault), .o_malformed(o_malformed)
);

`default_nettype wire

// *** dmsc_xl_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// Translation stage stand-in: takes each piece and answers once
// ************************************************************
module dmsc_xl_model (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_valid,
  input  wire logic i_slow,
  input  wire logic i_fault,
  input  wire logic i_rd_only,
  output logic      o_ready,
  output logic      o_done,
  output logic      o_fault,
  output logic      o_rd_perm_only
);
  logic       taken_q;
  logic [1:0] wait_q;

  // Remember which rising edge really took a piece.
  always @(posedge i_clk) begin
    taken_q <= i_valid && o_ready;
  end

  // Answers move on the falling edge; idle fault lines flip so stale values never look valid.
  always @(negedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
      o_done <= 1'b0;
      o_fault <= 1'b0;
      o_rd_perm_only <= 1'b0;
      wait_q <= 2'h0;
    end else begin
      o_done <= taken_q;
      o_fault <= taken_q ? i_fault : ~o_fault;
      o_rd_perm_only <= taken_q ? i_rd_only : ~o_rd_perm_only;
      if (taken_q || !i_valid) begin
        o_ready <= 1'b0;
        wait_q <= 2'h0;
      end else if (!o_ready) begin
        wait_q <= wait_q + 2'h1;
        o_ready <= !i_slow || wait_q == 2'h2;
      end
    end
  end
endmodule : dmsc_xl_model

`default_nettype wire

// *** tb_dma_request_screening.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb_dma_request_screening;
  import dmsc_pkg::*;
  logic clk, rst_n, rej, vld, rdy, pv, slow, flt, rdo, xv, xr, xd, xf, xo, zs, dn, xpv, xzl;
  logic [15:0] rid, xrid, erid;
  logic [19:0] pasid, xpas;
  logic [63:0] addr, xaddr, eaddr;
  logic [9:0]  len;
  logic [10:0] xlen;
  logic [3:0]  fbe, lbe;
  // Eight output pins land on separate bits, so this must be a net.
  wire [7:0]   flg;
  dmsc_kind_e  kind, xkind;
  int          comparisons = 0;
  int          miscompares = 0;

  dmsc_screen dut (.i_clk(clk), .i_rst_n(rst_n), .i_platform_rejects_cross(rej), .i_req_valid(vld),
    .o_req_ready(rdy), .i_req_rid(rid), .i_req_pasid_vld(pv), .i_req_pasid(pasid), .i_req_kind(kind),
    .i_req_addr(addr), .i_req_len(len), .i_req_first_be(fbe), .i_req_last_be(lbe), .o_xl_valid(xv),
    .i_xl_ready(xr), .o_xl_rid(xrid), .o_xl_pasid_vld(xpv), .o_xl_pasid(xpas), .o_xl_kind(xkind),
    .o_xl_addr(xaddr), .o_xl_len_dw(xlen), .o_xl_zero_len(xzl), .i_xl_done(xd), .i_xl_fault(xf),
    .i_xl_rd_perm_only(xo),
    .o_zero_len_read_support(zs), .o_done(dn), .o_cpl_ok(flg[7]), .o_cpl_be_off(flg[6]),
    .o_cpl_obfuscate(flg[5]), .o_cpl_bypass(flg[4]), .o_irq_msg(flg[3]), .o_irq_fault(flg[2]),
    .o_malformed(flg[1]), .o_xl_fault_rpt(flg[0]), .o_err_addr(eaddr), .o_err_rid(erid));

  dmsc_xl_model u_xl (.i_clk(clk), .i_rst_n(rst_n), .i_valid(xv), .i_slow(slow), .i_fault(flt),
    .i_rd_only(rdo), .o_ready(xr), .o_done(xd), .o_fault(xf), .o_rd_perm_only(xo));

  // One comparison; any difference is reported on the spot.
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // Expected flags {ok, be_off, obfuscate, bypass, irq_msg, irq_fault, malformed, xl_fault}.
  function automatic logic [7:0] exp_of(input dmsc_kind_e k, input logic [63:0] a, input logic [10:0] n,
                                        input logic [3:0] fb, input logic p, r, f, o);
    logic zl, win, cr;
    zl = k == DMSC_RD && n == 11'h001 && fb == 4'h0;
    win = !p && a[63:32] == 32'h0 && a[31:20] == IRQ_WIN_TAG;
    cr = ({2'h0, a[11:0]} + {1'b0, n, 2'h0}) > 14'h1000;
    if (r && cr) return 8'h02;
    if (win && zl) return 8'hF0;
    if (win) return (k == DMSC_WR && n == 11'h001) ? 8'h08 : 8'h04;
    if (f && !(zl && o)) return 8'h01;
    return zl ? (f ? 8'hE0 : 8'hC0) : 8'h80;
  endfunction : exp_of

  // One request from offer to completion, checking every piece on the way.
  task automatic run_req(input dmsc_kind_e k, input logic [63:0] a, input logic [9:0] l,
                         input logic [3:0] fb, input logic p, r, f, o);
    logic [10:0] rem, room, n;
    logic [63:0] na;
    logic [7:0]  e;
    logic        seen;
    int          t;
    rem = (l == 10'h0) ? 11'h400 : {1'b0, l};
    e = exp_of(k, a, rem, fb, p, r, f, o);
    na = a;
    seen = 1'b0;
    t = 0;
    @(negedge clk);
    kind = k;
    addr = a;
    len = l;
    fbe = fb;
    lbe = (rem == 11'h001) ? 4'h0 : 4'hF;
    pv = p;
    rej = r;
    flt = f;
    rdo = o;
    rid = $urandom_range(1) ? {8'($urandom), 8'h00} : 16'($urandom);
    pasid = 20'($urandom);
    slow = 1'($urandom);
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    chk(64'(rdy), 64'h0);
    while (dn !== 1'b1 && t < 3000) begin
      if (xv === 1'b1 && !seen) begin
        room = 11'((13'h1000 - {1'b0, na[11:0]}) >> 2);
        n = (rem < room) ? rem : room;
        chk(xaddr, na);
        chk(64'(xlen), 64'(n));
        chk(64'(xrid), 64'(rid));
        chk(64'(xpv), 64'(p));
        chk(64'(xpas), 64'(pasid));
        chk(64'(xkind), 64'(k));
        chk(64'(xzl), 64'(k == DMSC_RD && l == 10'h001 && fb == 4'h0));
        na = na + {51'h0, n, 2'h0};
        rem = rem - n;
      end
      seen = xv;
      @(negedge clk);
      t++;
    end
    chk(64'(dn), 64'h1);
    chk(64'(rdy), 64'h1);
    chk(64'(erid), 64'(rid));
    chk(64'(flg), 64'(e));
    chk(eaddr, a);
    chk((e[4:1] == 4'h0) ? 64'(rem) : na - a, 64'h0);
    $display("test done kind %0h addr %0h len %0h flags %0h", k, a, l, flg);
  endtask : run_req

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  initial begin : main
    dmsc_kind_e kinds[3];
    logic [11:0] tag;
    kinds = '{DMSC_RD, DMSC_WR, DMSC_AT};
    {rst_n, rej, vld, pv, slow, flt, rdo} = 7'h0;
    {rid, pasid, addr, len, fbe, lbe} = '0;
    kind = DMSC_RD;
    void'($urandom(32'hAFDC51EC));
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(64'(zs), 64'h1);
    run_req(DMSC_RD, 64'h0000_0012_3456_7100, 10'h001, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    run_req(DMSC_RD, 64'h0000_0012_3456_7100, 10'h001, 4'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    run_req(DMSC_RD, 64'h0000_0012_3456_7100, 10'h001, 4'h0, 1'b1, 1'b0, 1'b1, 1'b0);
    run_req(DMSC_RD, 64'h0000_0000_FEE0_0040, 10'h001, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0);
    run_req(DMSC_WR, 64'h0000_0000_FEE1_2340, 10'h001, 4'hF, 1'b0, 1'b0, 1'b0, 1'b0);
    run_req(DMSC_WR, 64'h0000_0000_FEEF_FFF8, 10'h002, 4'hF, 1'b0, 1'b0, 1'b0, 1'b0);
    run_req(DMSC_AT, 64'h0000_0000_FEE0_0100, 10'h001, 4'hF, 1'b0, 1'b0, 1'b0, 1'b0);
    run_req(DMSC_WR, 64'h0000_0000_FEE0_0100, 10'h001, 4'hF, 1'b1, 1'b0, 1'b0, 1'b0);
    run_req(DMSC_WR, 64'h0000_0001_0000_0FF8, 10'h004, 4'hF, 1'b0, 1'b1, 1'b0, 1'b0);
    run_req(DMSC_RD, 64'h0000_0001_0000_0004, 10'h000, 4'hF, 1'b0, 1'b0, 1'b0, 1'b0);
    run_req(DMSC_WR, 64'h0000_0001_0000_0FF0, 10'h010, 4'hF, 1'b0, 1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 60; i++) begin
      tag = ($urandom_range(2) == 0) ? IRQ_WIN_TAG : 12'($urandom);
      run_req(kinds[$urandom_range(2)], {32'h0, tag, 8'($urandom), 10'($urandom), 2'h0},
              ($urandom_range(2) == 0) ? 10'h001 : 10'($urandom_range(300)),
              ($urandom_range(2) == 0) ? 4'h0 : 4'hF, 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
    end
    complete_run();
  end
endmodule : tb_dma_request_screening

`default_nettype wire
